// file: swd_pkg.sv
// Summary of operation
// - Two key writes reload counter from timing count
// - Unserviced time-out raises chip reset request
// - No time limit between both keys
// - Other value abandons partial key sequence
// - Service register writable at any time
// - Service register always reads zero
// - Timing count in low 24 bits
// - Enable bit stops or runs counter
// - Lock bit blocks control register writes
// - Debug mode lets software clear lock
// - Control register always readable
// - Counter decrements once per enabled cycle
// - Zero timing count gives longest time-out
// - Count register read-only, shows live count
package swd_pkg;

    ////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [31:0] ADDR_SERVICE = 32'h8007efc0;
    localparam logic [31:0] ADDR_CONTROL = 32'h8007efc4;
    localparam logic [31:0] ADDR_COUNT = 32'h8007efc8;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'h8007efe0;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h8007efe4;

    ////////////////////////////////////////////////////////////////
    // Service keys, carried in the upper half word
    localparam logic [15:0] KEY_FIRST = 16'h556c;
    localparam logic [15:0] KEY_SECOND = 16'haa39;
    localparam int KEY_MSB = 31;
    localparam int KEY_LSB = 16;

    ////////////////////////////////////////////////////////////////
    // Control register layout and reset values
    localparam int TC_W = 24;
    localparam int EN_POS = 25;
    localparam int LOCK_POS = 24;
    localparam logic EN_RESET = 1'h1;
    localparam logic LOCK_RESET = 1'h0;
    localparam logic [TC_W-1:0] TC_RESET = 24'hffffff;
    localparam logic [TC_W-1:0] CNT_RESET = 24'hffffff;
    localparam logic [TC_W-1:0] CNT_ONE = 24'h000001;
    localparam logic [TC_W-1:0] CNT_ZERO = 24'h000000;

    ////////////////////////////////////////////////////////////////
    // Interrupt status and mask layout
    localparam int EV_W = 3;
    localparam int EV_TIMEOUT = 0;
    localparam int EV_SERVICED = 1;
    localparam int EV_BADKEY = 2;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    // Control register contents
    typedef struct packed {
        logic watchdog_enable_bit;
        logic watchdog_lock_bit;
        logic [TC_W-1:0] timing_count;
    } swd_ctl_s;

    // Progress of the two-key service sequence
    typedef enum logic {
        SEQ_IDLE,
        SEQ_ARMED
    } swd_seq_e;

endpackage

// file: swd_watchdog.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module swd_watchdog
    import swd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic dbg_mode_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic chip_reset_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////
    // Functions

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_sel(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Packs the control register into its bus image
    function automatic logic [31:0] ctl_word(input swd_ctl_s c);
        logic [31:0] w;
        w = 32'h00000000;
        w[EN_POS] = c.watchdog_enable_bit;
        w[LOCK_POS] = c.watchdog_lock_bit;
        w[TC_W-1:0] = c.timing_count;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Declarations
    logic dbg_meta_reg;
    logic dbg_sync_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    swd_ctl_s ctl_reg;
    swd_ctl_s ctl_next;
    swd_seq_e seq_reg;
    logic [TC_W-1:0] live_count_reg;
    logic expired_reg;
    logic rst_req_reg;
    logic [EV_W-1:0] stat_reg;
    logic [EV_W-1:0] mask_reg;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] stat_clr;
    logic req;
    logic wr_fire;
    logic svc_wr;
    logic ctl_wr;
    logic [15:0] key;
    logic key_ok;
    logic is_first;
    logic is_second;
    logic reload;
    logic run;
    logic expire;
    logic [31:0] ctl_merged;
    logic [31:0] rd_mux;
    logic [31:0] mask_merged;

    ////////////////////////////////////////////////////////////////
    // Debug mode arrives from outside the clock domain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbg_meta_reg <= 1'h0;
            dbg_sync_reg <= 1'h0;
        end else if (ce_i) begin
            dbg_meta_reg <= dbg_mode_i;
            dbg_sync_reg <= dbg_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the request is seen,
    // writes take effect on the edge that samples ack
    assign req = cyc_i && stb_i && ce_i;
    assign wr_fire = req && we_i && ack_reg;
    assign svc_wr = wr_fire && (adr_i == ADDR_SERVICE);
    assign ctl_wr = wr_fire && (adr_i == ADDR_CONTROL);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'h0;
        end else if (ce_i) begin
            ack_reg <= cyc_i && stb_i && !ack_reg;
        end
    end

    assign ack_o = ack_reg;

    // Read mux; unmapped and write-only locations read zero
    always_comb begin
        rd_mux = 32'h00000000;
        case (adr_i)
            ADDR_SERVICE: rd_mux = 32'h00000000;
            ADDR_CONTROL: rd_mux = ctl_word(ctl_reg);
            ADDR_COUNT: rd_mux[TC_W-1:0] = live_count_reg;
            ADDR_IRQ_STAT: rd_mux[EV_W-1:0] = stat_reg;
            ADDR_IRQ_MASK: rd_mux[EV_W-1:0] = mask_reg;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h00000000;
        end else if (req && !ack_reg) begin
            rdata_reg <= we_i ? 32'h00000000 : rd_mux;
        end
    end

    assign dat_o = rdata_reg;

    ////////////////////////////////////////////////////////////////
    // Key decode; a write missing either upper byte lane is not a key
    assign key = dat_i[KEY_MSB:KEY_LSB];
    assign key_ok = (sel_i[3:2] == 2'h3);
    assign is_first = key_ok && (key == KEY_FIRST);
    assign is_second = key_ok && (key == KEY_SECOND);

    // Sequence tracker; no timer runs while armed, so the
    // second key may come arbitrarily late
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_reg <= SEQ_IDLE;
        end else if (svc_wr) begin
            case (seq_reg)
                SEQ_IDLE: begin
                    if (is_first) begin
                        seq_reg <= SEQ_ARMED;
                    end
                end
                SEQ_ARMED: begin
                    if (is_first) begin
                        seq_reg <= SEQ_ARMED;
                    end else begin
                        seq_reg <= SEQ_IDLE;
                    end
                end
                default: seq_reg <= SEQ_IDLE;
            endcase
        end
    end

    // Second key after an armed first key completes the service
    assign reload = svc_wr && (seq_reg == SEQ_ARMED) && is_second
        && !expired_reg;

    ////////////////////////////////////////////////////////////////
    // Control register with lock; debug mode may only drop the lock
    assign ctl_merged = merge_sel(ctl_word(ctl_reg), dat_i, sel_i);

    always_comb begin
        ctl_next = ctl_reg;
        if (ctl_wr) begin
            if (!ctl_reg.watchdog_lock_bit) begin
                ctl_next.watchdog_enable_bit = ctl_merged[EN_POS];
                ctl_next.watchdog_lock_bit = ctl_merged[LOCK_POS];
                ctl_next.timing_count = ctl_merged[TC_W-1:0];
            end else if (dbg_sync_reg && sel_i[3]) begin
                if (!dat_i[LOCK_POS]) begin
                    ctl_next.watchdog_lock_bit = 1'h0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg.watchdog_enable_bit <= EN_RESET;
            ctl_reg.watchdog_lock_bit <= LOCK_RESET;
            ctl_reg.timing_count <= TC_RESET;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Down counter; reload beats the decrement in the same cycle.
    // Expiry is the step from one to zero, so a timing count of
    // zero wraps first and gives the full 2^24 cycle time-out.
    assign run = ce_i && ctl_reg.watchdog_enable_bit
        && !expired_reg;
    assign expire = run && !reload && (live_count_reg == CNT_ONE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            live_count_reg <= CNT_RESET;
        end else if (reload) begin
            live_count_reg <= ctl_reg.timing_count;
        end else if (run) begin
            live_count_reg <= live_count_reg - CNT_ONE;
        end
    end

    // Once expired the counter stays at zero until chip reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            expired_reg <= 1'h0;
            rst_req_reg <= 1'h0;
        end else if (ce_i) begin
            rst_req_reg <= expire;
            if (expire) begin
                expired_reg <= 1'h1;
            end
        end
    end

    assign chip_reset_o = rst_req_reg;

    ////////////////////////////////////////////////////////////////
    // Interrupt status: sticky, write one to clear, set wins
    assign ev_set[EV_TIMEOUT] = expire;
    assign ev_set[EV_SERVICED] = reload;
    assign ev_set[EV_BADKEY] = svc_wr && !is_first && !is_second;
    assign stat_clr = (wr_fire && (adr_i == ADDR_IRQ_STAT) && sel_i[0])
        ? dat_i[EV_W-1:0] : EV_RESET;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_reg <= EV_RESET;
        end else if (ce_i) begin
            stat_reg <= (stat_reg & ~stat_clr) | ev_set;
        end
    end

    // Byte lanes of a mask write merged onto the stored bits
    assign mask_merged = merge_sel({29'h0, mask_reg}, dat_i, sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= EV_RESET;
        end else if (wr_fire && (adr_i == ADDR_IRQ_MASK)) begin
            mask_reg <= mask_merged[EV_W-1:0];
        end
    end

    // Level interrupt while any unmasked status bit stands
    assign irq_o = |(stat_reg & mask_reg);

    ////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Completed service loads the timing count
    property p_service_reload;
        reload |=> live_count_reg == $past(ctl_reg.timing_count);
    endproperty
    a_service_reload: assert property (p_service_reload)
        else $error("service did not reload counter");

    // Step from one to zero raises reset next cycle, for one cycle
    property p_expire_reset;
        expire |=> chip_reset_o ##1 !chip_reset_o;
    endproperty
    a_expire_reset: assert property (p_expire_reset)
        else $error("expiry did not pulse chip reset");

    // Armed sequence survives cycles without service writes
    property p_armed_holds;
        (seq_reg == SEQ_ARMED) && !svc_wr |=> seq_reg == SEQ_ARMED;
    endproperty
    a_armed_holds: assert property (p_armed_holds)
        else $error("armed sequence lost without a write");

    // A non-key write drops the sequence and blocks a reload
    property p_bad_key;
        svc_wr && !is_first && !is_second
            |=> seq_reg == SEQ_IDLE && !reload;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("bad key did not abandon sequence");

    // Service reads answer zero
    property p_service_zero;
        req && !we_i && !ack_reg && adr_i == ADDR_SERVICE
            |=> ack_o && dat_o == 32'h00000000;
    endproperty
    a_service_zero: assert property (p_service_zero)
        else $error("service register read not zero");

    // Control reads return the stored fields
    property p_ctl_read;
        req && !we_i && !ack_reg && adr_i == ADDR_CONTROL
            |=> ack_o && dat_o == ctl_word($past(ctl_reg));
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control read mismatch");

    // Disabled counter keeps its value
    property p_enable_stops;
        !ctl_reg.watchdog_enable_bit && !reload
            |=> $stable(live_count_reg);
    endproperty
    a_enable_stops: assert property (p_enable_stops)
        else $error("disabled counter moved");

    // Locked control ignores writes outside debug mode
    property p_lock_blocks;
        ctl_wr && ctl_reg.watchdog_lock_bit && !dbg_sync_reg
            |=> $stable(ctl_reg);
    endproperty
    a_lock_blocks: assert property (p_lock_blocks)
        else $error("locked control register changed");

    // Debug write with lock clear drops the lock
    property p_debug_unlock;
        ctl_wr && ctl_reg.watchdog_lock_bit && dbg_sync_reg
            && sel_i[3] && !dat_i[LOCK_POS]
            |=> !ctl_reg.watchdog_lock_bit;
    endproperty
    a_debug_unlock: assert property (p_debug_unlock)
        else $error("debug mode did not clear lock");

    // Running counter steps down by one
    property p_decrement;
        !rst_i && run && !reload |=> live_count_reg
            == $past(live_count_reg) - CNT_ONE;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("counter did not decrement by one");

    // Zero wraps to full scale rather than expiring
    property p_zero_wraps;
        run && !reload && live_count_reg == CNT_ZERO
            |=> live_count_reg == CNT_RESET && !expired_reg;
    endproperty
    a_zero_wraps: assert property (p_zero_wraps)
        else $error("zero count did not wrap");

    // Expired state holds the counter and never re-requests
    property p_expired_hold;
        expired_reg |=> expired_reg && live_count_reg == CNT_ZERO
            && !expire;
    endproperty
    a_expired_hold: assert property (p_expired_hold)
        else $error("expired watchdog did not hold");

    // Clock enable low freezes the counter, sequence and status
    property p_ce_freeze;
        !ce_i |=> $stable(live_count_reg) && $stable(seq_reg)
            && $stable(stat_reg) && $stable(ack_o);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state moved while clock enable low");

    // Writes to the count register leave a stopped counter alone
    property p_count_ro;
        wr_fire && adr_i == ADDR_COUNT && !run
            |=> $stable(live_count_reg);
    endproperty
    a_count_ro: assert property (p_count_ro)
        else $error("count register write changed the counter");

    // A full first key arms the sequence from any state
    property p_first_arms;
        svc_wr && is_first |=> seq_reg == SEQ_ARMED;
    endproperty
    a_first_arms: assert property (p_first_arms)
        else $error("first key did not arm the sequence");

endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top
    import swd_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic dbg_mode_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [31:0] adr_i = 32'h00000000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic [31:0] dat_o;
    logic ack_o;
    logic chip_reset_o;
    logic irq_o;
    int err_total = 0;
    int total_checks = 0;
    int pulses = 0;
    int base;
    logic [31:0] c1;
    logic [31:0] c2;

    ////////////////////////////////////////////////////////////////
    // Clock at 25 MHz
    always #20 clk_i = ~clk_i;

    // Count reset request pulses, one per high cycle
    always @(posedge clk_i) begin
        if (chip_reset_o === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    swd_watchdog i_swd_watchdog (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .dbg_mode_i(dbg_mode_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .chip_reset_o(chip_reset_o),
        .irq_o(irq_o)
    );

    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; a hang here is cut short by the watchdog below
    task automatic bus(input logic we, input logic [31:0] adr,
                       input logic [31:0] dat, output logic [31:0] data);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= adr;
        dat_i <= dat;
        sel_i <= 4'hf;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        data = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        bus(1'b1, adr, dat, d);
    endtask

    task automatic rdc(input logic [31:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, adr, 32'h00000000, d);
        chk(d, exp);
    endtask

    task automatic svc();
        wr(ADDR_SERVICE, {KEY_FIRST, 16'h0000});
        wr(ADDR_SERVICE, {KEY_SECOND, 16'h0000});
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////
    // Generous bound: the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        complete_run();
    end

    // Main sequence
    initial begin
        do_reset();
        rdc(ADDR_CONTROL, 32'h02ffffff);
        rdc(ADDR_SERVICE, 32'h00000000);
        rdc(ADDR_IRQ_STAT, 32'h00000000);
        rdc(ADDR_IRQ_MASK, 32'h00000000);
        rdc(32'h8007efcc, 32'h00000000);
        $display("test reset values done");
        // Stopped counter, so reload effects are exact
        wr(ADDR_CONTROL, 32'h00000010);
        rdc(ADDR_CONTROL, 32'h00000010);
        bus(1'b0, ADDR_COUNT, 32'h00000000, c1);
        wr(ADDR_COUNT, 32'h00000055);
        bus(1'b0, ADDR_COUNT, 32'h00000000, c2);
        chk(c2, c1);
        wr(ADDR_SERVICE, {KEY_FIRST, 16'h0000});
        wr(ADDR_SERVICE, 32'h12340000);
        wr(ADDR_SERVICE, {KEY_SECOND, 16'h0000});
        bus(1'b0, ADDR_COUNT, 32'h00000000, c2);
        chk(c2, c1);
        rdc(ADDR_SERVICE, 32'h00000000);
        wr(ADDR_SERVICE, {KEY_FIRST, 16'h0000});
        rdc(ADDR_CONTROL, 32'h00000010);
        wr(ADDR_SERVICE, {KEY_SECOND, 16'h0000});
        rdc(ADDR_COUNT, 32'h00000010);
        rdc(ADDR_IRQ_STAT, 32'h00000006);
        chk({31'h0, irq_o}, 32'h00000000);
        wr(ADDR_IRQ_MASK, 32'h00000004);
        chk({31'h0, irq_o}, 32'h00000001);
        wr(ADDR_IRQ_STAT, 32'h00000004);
        chk({31'h0, irq_o}, 32'h00000000);
        rdc(ADDR_IRQ_STAT, 32'h00000002);
        $display("test service sequence done");
        // Running counter: reads taken three cycles apart
        wr(ADDR_CONTROL, 32'h00000100);
        svc();
        wr(ADDR_CONTROL, 32'h02000100);
        bus(1'b0, ADDR_COUNT, 32'h00000000, c1);
        bus(1'b0, ADDR_COUNT, 32'h00000000, c2);
        chk(c2, c1 - 32'h00000003);
        // Clock enable low for five cycles holds the counter
        ce_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        ce_i <= 1'b1;
        bus(1'b0, ADDR_COUNT, 32'h00000000, c1);
        chk(c1, c2 - 32'h00000003);
        // Short time-out left unserviced
        wr(ADDR_CONTROL, 32'h02000010);
        base = pulses;
        svc();
        repeat (8) @(posedge clk_i);
        chk(pulses - base, 0);
        repeat (30) @(posedge clk_i);
        chk(pulses - base, 1);
        rdc(ADDR_COUNT, 32'h00000000);
        svc();
        rdc(ADDR_COUNT, 32'h00000000);
        wr(ADDR_IRQ_MASK, 32'h00000001);
        chk({31'h0, irq_o}, 32'h00000001);
        $display("test expiry done");
        // Lock, then unlock only under debug mode
        do_reset();
        wr(ADDR_CONTROL, 32'h03000020);
        rdc(ADDR_CONTROL, 32'h03000020);
        wr(ADDR_CONTROL, 32'h00000040);
        rdc(ADDR_CONTROL, 32'h03000020);
        dbg_mode_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        wr(ADDR_CONTROL, 32'h02000040);
        rdc(ADDR_CONTROL, 32'h02000020);
        wr(ADDR_CONTROL, 32'h02000040);
        rdc(ADDR_CONTROL, 32'h02000040);
        dbg_mode_i <= 1'b0;
        $display("test lock done");
        // Zero timing count must not expire at once
        wr(ADDR_CONTROL, 32'h02000000);
        base = pulses;
        svc();
        bus(1'b0, ADDR_COUNT, 32'h00000000, c1);
        chk({31'h0, c1[23:0] > 24'hff0000}, 32'h00000001);
        repeat (40) @(posedge clk_i);
        chk(pulses - base, 0);
        $display("test zero count done");
        complete_run();
    end
endmodule
